// [rtl/pdsr_pkg.sv]
package pdsr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam logic [8:0] OFF_PORT1_PIN_STRENGTH = 9'h1f0;
    localparam logic [8:0] OFF_PORT2_PIN_STRENGTH = 9'h1f1;
    localparam logic [8:0] OFF_GROUP_STRENGTH_A = 9'h1f2;
    localparam logic [8:0] OFF_GROUP_STRENGTH_B = 9'h1f3;

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_STRENGTH = 8'h00;
    localparam logic [7:0] MASK_PIN_STRENGTH = 8'hff;
    localparam logic [7:0] MASK_GROUP_A = 8'hc3;
    localparam logic [7:0] MASK_GROUP_B = 8'h3b;

    // ------------------------------------------------------------
    // Field positions in the group registers
    // ------------------------------------------------------------
    localparam int BIT_P0_LOW_NIBBLE = 0;
    localparam int BIT_P0_HIGH_NIBBLE = 1;
    localparam int BIT_P3_LOW_NIBBLE = 6;
    localparam int BIT_P3_HIGH_NIBBLE = 7;
    localparam int BIT_P4_PIN3 = 0;
    localparam int BIT_P4_HIGH_NIBBLE = 1;
    localparam int BIT_P5_UPPER_PAIR = 3;
    localparam int BIT_P6_LOW_NIBBLE = 4;
    localparam int BIT_P6_HIGH_NIBBLE = 5;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pdsr_bus_req_s;

    // One byte per port, bit i is pin i
    typedef struct packed {
        logic [7:0] p6;
        logic [7:0] p5;
        logic [7:0] p4;
        logic [7:0] p3;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } pdsr_ports_s;

endpackage

// [rtl/pdsr_pad_map.sv]
`timescale 1ns/1ps
`default_nettype none
module pdsr_pad_map
    import pdsr_pkg::*;
(
    // Stored strength settings
    input wire logic [7:0] port1_pin_strength,
    input wire logic [7:0] port2_pin_strength,
    input wire logic [7:0] group_strength_a,
    input wire logic [7:0] group_strength_b,
    // Pin expansion
    output pdsr_ports_s pin_strength
);

    function automatic logic [3:0] nib(input logic b);
        nib = {4{b}};
    endfunction

    always_comb
    begin
        pin_strength = '0;
        pin_strength.p1 = port1_pin_strength; // RQ1
        pin_strength.p2 = port2_pin_strength; // RQ2
        pin_strength.p0 = {nib(group_strength_a[BIT_P0_HIGH_NIBBLE]),
            nib(group_strength_a[BIT_P0_LOW_NIBBLE])}; // RQ5
        pin_strength.p3 = {nib(group_strength_a[BIT_P3_HIGH_NIBBLE]),
            nib(group_strength_a[BIT_P3_LOW_NIBBLE])}; // RQ5
        pin_strength.p4 = {nib(group_strength_b[BIT_P4_HIGH_NIBBLE]),
            group_strength_b[BIT_P4_PIN3], 3'h0}; // RQ6
        pin_strength.p5 = {{2{group_strength_b[BIT_P5_UPPER_PAIR]}},
            6'h00}; // RQ6
        pin_strength.p6 = {nib(group_strength_b[BIT_P6_HIGH_NIBBLE]),
            nib(group_strength_b[BIT_P6_LOW_NIBBLE])}; // RQ6
    end

endmodule // pdsr_pad_map
`default_nettype wire

// [rtl/pdsr_regs.sv]
// Function
// RQ1: Port 1 per-pin strength register
// RQ2: Port 2 per-pin strength register
// RQ3: High strength applies to both levels
// RQ4: Strength acts only on output pins
// RQ5: Group A maps port 0, 3 nibbles
// RQ6: Group B maps ports 4, 5, 6
// RQ7: Unassigned group bits read zero
// RQ8: Pad select is bit and direction
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pdsr_regs
    import pdsr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Register port
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Pin direction, 1 is output
    input wire pdsr_ports_s pin_dir_out,
    // Pad strength selects, 1 is high for both levels
    output pdsr_ports_s pad_high_drive
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] port1_pin_strength;
        logic [7:0] port2_pin_strength;
        logic [7:0] group_strength_a;
        logic [7:0] group_strength_b;
        logic [7:0] rdata;
    } pdsr_state_s;

    // One select line per register
    localparam int NUM_REGS = 4;
    localparam int SEL_PORT1 = 0;
    localparam int SEL_PORT2 = 1;
    localparam int SEL_GROUP_A = 2;
    localparam int SEL_GROUP_B = 3;

    typedef logic [NUM_REGS-1:0] pdsr_sel_t;

    // Register side
    pdsr_state_s st_q;
    pdsr_state_s st_d;
    pdsr_bus_req_s bus_req;
    pdsr_sel_t bus_sel;
    logic [7:0] bus_mask;
    logic [7:0] wr_bits;
    // Pad side
    pdsr_ports_s pin_strength;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // One-hot register select, zero when unmapped
    function automatic pdsr_sel_t reg_select(input logic [ADDR_W-1:0] addr);
        reg_select = '0;
        unique case (addr)
            OFF_PORT1_PIN_STRENGTH:
                reg_select[SEL_PORT1] = 1'b1;
            OFF_PORT2_PIN_STRENGTH:
                reg_select[SEL_PORT2] = 1'b1;
            OFF_GROUP_STRENGTH_A:
                reg_select[SEL_GROUP_A] = 1'b1;
            OFF_GROUP_STRENGTH_B:
                reg_select[SEL_GROUP_B] = 1'b1;
            default:
                reg_select = '0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Implemented bits
    // ------------------------------------------------------------
    // Bits that exist in the selected register
    function automatic logic [7:0] field_mask(input pdsr_sel_t sel);
        field_mask = 8'h00;
        if (sel[SEL_PORT1] || sel[SEL_PORT2])
        begin
            field_mask = MASK_PIN_STRENGTH;
        end
        if (sel[SEL_GROUP_A])
        begin
            field_mask = MASK_GROUP_A; // RQ7
        end
        if (sel[SEL_GROUP_B])
        begin
            field_mask = MASK_GROUP_B; // RQ7
        end
    endfunction

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    // Stored value of the selected register
    function automatic logic [7:0] read_mux(input pdsr_sel_t sel,
        input pdsr_state_s s);
        read_mux = 8'h00;
        if (sel[SEL_PORT1])
        begin
            read_mux = s.port1_pin_strength;
        end
        if (sel[SEL_PORT2])
        begin
            read_mux = s.port2_pin_strength;
        end
        if (sel[SEL_GROUP_A])
        begin
            read_mux = s.group_strength_a;
        end
        if (sel[SEL_GROUP_B])
        begin
            read_mux = s.group_strength_b;
        end
    endfunction

    // ------------------------------------------------------------
    // Bus request
    // ------------------------------------------------------------
    always_comb
    begin
        bus_req.addr = reg_addr;
        bus_req.wdata = reg_wdata;
        bus_req.wr = reg_wr;
        bus_req.rd = reg_rd;
    end

    assign bus_sel = reg_select(bus_req.addr);
    assign bus_mask = field_mask(bus_sel);
    assign wr_bits = bus_req.wdata & bus_mask;

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.rdata = 8'h00;
        // Write path, unassigned bits dropped
        if (bus_req.wr && bus_sel[SEL_PORT1])
        begin
            st_d.port1_pin_strength = wr_bits; // RQ1
        end
        if (bus_req.wr && bus_sel[SEL_PORT2])
        begin
            st_d.port2_pin_strength = wr_bits; // RQ2
        end
        if (bus_req.wr && bus_sel[SEL_GROUP_A])
        begin
            st_d.group_strength_a = wr_bits; // RQ7
        end
        if (bus_req.wr && bus_sel[SEL_GROUP_B])
        begin
            st_d.group_strength_b = wr_bits; // RQ7
        end
        // Read path, data stands one cycle
        if (bus_req.rd)
        begin
            st_d.rdata = read_mux(bus_sel, st_q) & bus_mask; // RQ7
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_q.port1_pin_strength <= RST_STRENGTH;
            st_q.port2_pin_strength <= RST_STRENGTH;
            st_q.group_strength_a <= RST_STRENGTH;
            st_q.group_strength_b <= RST_STRENGTH;
            st_q.rdata <= 8'h00;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    assign reg_rdata = st_q.rdata;

    // ------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------
    pdsr_pad_map pdsr_pad_map_i (
        .port1_pin_strength(st_q.port1_pin_strength),
        .port2_pin_strength(st_q.port2_pin_strength),
        .group_strength_a(st_q.group_strength_a),
        .group_strength_b(st_q.group_strength_b),
        .pin_strength(pin_strength)
    );

    // ------------------------------------------------------------
    // Direction gating
    // ------------------------------------------------------------
    // One select per pin drives both the high and low output stage
    function automatic logic [7:0] out_gate(input logic [7:0] strength,
        input logic [7:0] dir);
        out_gate = strength & dir; // RQ3 RQ4
    endfunction

    always_comb
    begin
        pad_high_drive.p0 = out_gate(pin_strength.p0, pin_dir_out.p0); // RQ8
        pad_high_drive.p1 = out_gate(pin_strength.p1, pin_dir_out.p1); // RQ8
        pad_high_drive.p2 = out_gate(pin_strength.p2, pin_dir_out.p2); // RQ8
        pad_high_drive.p3 = out_gate(pin_strength.p3, pin_dir_out.p3); // RQ8
        pad_high_drive.p4 = out_gate(pin_strength.p4, pin_dir_out.p4); // RQ8
        pad_high_drive.p5 = out_gate(pin_strength.p5, pin_dir_out.p5); // RQ8
        pad_high_drive.p6 = out_gate(pin_strength.p6, pin_dir_out.p6); // RQ8
    end

endmodule // pdsr_regs
`default_nettype wire

// [verification/pdsr_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module pdsr_regs_asserts
    import pdsr_pkg::*;
(
    // Clock, reset, register port
    input wire logic mclk, srst, reg_wr, reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata,
    // Pins
    input wire pdsr_ports_s pin_dir_out, pad_high_drive
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("idle rdata");
    pad_dir_a: assert property (
        (pad_high_drive & ~pin_dir_out) == 56'h0) else $error("input pad");
    unused_pins_a: assert property (
        pad_high_drive.p4[2:0] == 3'h0 && pad_high_drive.p5[5:0] == 6'h0)
        else $error("unused pad");
    p0_nibble_a: assert property (
        pad_high_drive.p0[3:0] ==
        (pin_dir_out.p0[3:0] & {4{|pad_high_drive.p0[3:0]}}))
        else $error("p0 nibble");
    p1_write_a: assert property (
        reg_wr && reg_addr == OFF_PORT1_PIN_STRENGTH |=>
        pad_high_drive.p1 == ($past(reg_wdata) & pin_dir_out.p1))
        else $error("p1 write");
    p2_write_a: assert property (
        reg_wr && reg_addr == OFF_PORT2_PIN_STRENGTH |=>
        pad_high_drive.p2 == ($past(reg_wdata) & pin_dir_out.p2))
        else $error("p2 write");
    group_a_read_a: assert property (
        reg_rd && reg_addr == OFF_GROUP_STRENGTH_A |=>
        (reg_rdata & ~MASK_GROUP_A) == 8'h00) else $error("group a bits");
    group_b_read_a: assert property (
        reg_rd && reg_addr == OFF_GROUP_STRENGTH_B |=>
        (reg_rdata & ~MASK_GROUP_B) == 8'h00) else $error("group b bits");
endmodule // pdsr_regs_asserts
bind pdsr_regs pdsr_regs_asserts pdsr_regs_asserts_i (.mclk(mclk),
    .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pin_dir_out(pin_dir_out), .pad_high_drive(pad_high_drive));
`default_nettype wire

// [verification/test_port_drive_strength_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module test_port_drive_strength_regs
    import pdsr_pkg::*;
;
    logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    pdsr_ports_s pin_dir_out = '1, pad_high_drive;
    int num_errors = 0, total_checks = 0, cycles = 0;
    pdsr_regs pdsr_regs_i (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_dir_out(pin_dir_out),
        .pad_high_drive(pad_high_drive));
    always #20 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 400)
        begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(logic [55:0] s, logic [55:0] e);
        total_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(logic [8:0] a, logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [8:0] a, logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(56'(reg_rdata), 56'(e));
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        rd(OFF_PORT1_PIN_STRENGTH, RST_STRENGTH);
        rd(OFF_PORT2_PIN_STRENGTH, RST_STRENGTH);
        rd(OFF_GROUP_STRENGTH_A, RST_STRENGTH);
        rd(OFF_GROUP_STRENGTH_B, RST_STRENGTH);
        check(pad_high_drive, 56'h0);
        wr(OFF_PORT1_PIN_STRENGTH, 8'hff);
        wr(OFF_PORT2_PIN_STRENGTH, 8'ha5);
        wr(OFF_GROUP_STRENGTH_A, 8'h41);
        wr(OFF_GROUP_STRENGTH_B, 8'h11);
        check(pad_high_drive, 56'h0f_00_08_0f_a5_ff_0f);
        wr(OFF_GROUP_STRENGTH_A, 8'hff);
        wr(OFF_GROUP_STRENGTH_B, 8'hff);
        check(pad_high_drive, 56'hff_c0_f8_ff_a5_ff_ff);
        rd(OFF_GROUP_STRENGTH_A, MASK_GROUP_A);
        rd(OFF_GROUP_STRENGTH_B, MASK_GROUP_B);
        rd(OFF_PORT2_PIN_STRENGTH, 8'ha5);
        wr(9'h1f4, 8'hff);
        rd(9'h1f4, 8'h00);
        check(pad_high_drive, 56'hff_c0_f8_ff_a5_ff_ff);
        pin_dir_out <= 56'h55_55_55_55_55_55_55;
        @(posedge mclk);
        #1;
        check(pad_high_drive, 56'h55_40_50_55_05_55_55);
        @(posedge mclk);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        #1;
        check(pad_high_drive, 56'h0);
        rd(OFF_GROUP_STRENGTH_B, RST_STRENGTH);
        wrap_up();
    end
endmodule // test_port_drive_strength_regs
`default_nettype wire
